// [pkg/erg_pkg.sv]
// Purpose: shared constants of the excitation routing and pin control registers
// Assumes: 8-bit register port, byte offsets as printed
// Notes: field positions and codes are named once here

package erg_pkg;

  // ==========================================================
  // register port
  localparam int ERG_ADDR_W = 8;
  localparam int ERG_DATA_W = 8;
  localparam logic [7:0] ERG_ADDR_ROUTE = 8'h03;
  localparam logic [7:0] ERG_ADDR_PINS = 8'h04;
  localparam logic [7:0] ERG_RESET_ROUTE = 8'h00;
  localparam logic [7:0] ERG_RESET_PINS = 8'h00;
  localparam logic [7:0] ERG_READ_ZERO = 8'h00;

  // ==========================================================
  // routing register fields
  localparam int ERG_ONE_ROUTE_HI = 7;
  localparam int ERG_ONE_ROUTE_LO = 5;
  localparam int ERG_TWO_ROUTE_HI = 4;
  localparam int ERG_TWO_ROUTE_LO = 2;
  localparam int ERG_ROUTE_RSVD_BIT = 1;
  localparam int ERG_AUTO_BIT = 0;

  // ==========================================================
  // pin register fields
  localparam int ERG_PINS_RSVD_BIT = 7;
  localparam int ERG_DIR_LO = 4;
  localparam int ERG_PIN2_SEL_BIT = 3;
  localparam int ERG_LEVEL_LO = 0;
  localparam int ERG_NUM_PINS = 3;
  localparam int ERG_READY_PIN = 2;

  // ==========================================================
  // route codes and one-hot target selects
  localparam int ERG_NUM_TARGETS = 6;
  typedef enum logic [2:0] {
    ERG_ROUTE_OFF = 3'h0,
    ERG_ROUTE_ANALOG_INPUT_ZERO = 3'h1,
    ERG_ROUTE_ANALOG_INPUT_ONE = 3'h2,
    ERG_ROUTE_ANALOG_INPUT_TWO = 3'h3,
    ERG_ROUTE_ANALOG_INPUT_THREE = 3'h4,
    ERG_ROUTE_REFERENCE_POSITIVE_PIN = 3'h5,
    ERG_ROUTE_REFERENCE_NEGATIVE_PIN = 3'h6,
    ERG_ROUTE_RSVD = 3'h7
  } erg_route_t;

  localparam logic [5:0] ERG_SEL_NONE = 6'h00;
  localparam logic [5:0] ERG_SEL_ANALOG_INPUT_ZERO = 6'h01;
  localparam logic [5:0] ERG_SEL_ANALOG_INPUT_ONE = 6'h02;
  localparam logic [5:0] ERG_SEL_ANALOG_INPUT_TWO = 6'h04;
  localparam logic [5:0] ERG_SEL_ANALOG_INPUT_THREE = 6'h08;
  localparam logic [5:0] ERG_SEL_REFERENCE_POSITIVE_PIN = 6'h10;
  localparam logic [5:0] ERG_SEL_REFERENCE_NEGATIVE_PIN = 6'h20;

  // output modes of conversion results, pin directions and pin 2 sources
  localparam logic ERG_MODE_MANUAL = 1'b0;
  localparam logic ERG_MODE_AUTO = 1'b1;
  localparam logic ERG_DIR_INPUT = 1'b0;
  localparam logic ERG_DIR_OUTPUT = 1'b1;
  localparam logic ERG_PIN2_FROM_LEVEL = 1'b0;
  localparam logic ERG_PIN2_FROM_READY = 1'b1;

endpackage

// [verilog/erg_pin_cell.sv]
// Purpose: one general-purpose pin: input synchroniser and level bit
// Assumes: pin_in is asynchronous to ref_clk
// Notes: level bit follows the pin while the pin is an input

`timescale 1ns/1ns

module erg_pin_cell
  import erg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic dir,
  input wire logic wr_en,
  input wire logic wr_level,
  output logic level_q
);

  logic meta_q;
  logic sync_q;
  logic level_d;

  // ==========================================================
  // two-stage synchroniser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // level bit
  // input: capture the pin; output: hold what software wrote
  assign level_d = (dir == ERG_DIR_INPUT) ? sync_q :
                   (wr_en ? wr_level : level_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

endmodule

// [verilog/erg_config_regs.sv]
// Purpose: excitation routing, result output mode and pin control registers
// Assumes: single clock ref_clk, synchronous active-high reset rst
// Notes: register port with read data one cycle after the read strobe
//
// Behaviour
// - decode source one route, 111 reserved
// - decode source two route in bits 4:2
// - reserved bits read zero, host writes zero
// - bit 0 selects manual or automatic output
// - direction bits 6:4 set input or output
// - pin 2 output from level or ready
// - output pins drive their level bit, except pin 2 drives ready when ready is selected
// - input pins capture level into level bit
// - level one means high, resets low
// - pin register at 04h, resets 00h
// - ready sets on result, clears on read
//
// The implementer's own choice: strobed register access.

`timescale 1ns/1ns

module erg_config_regs
  import erg_pkg::*;
#(
  parameter int NUM_PINS = ERG_NUM_PINS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [ERG_ADDR_W-1:0] reg_addr,
  input wire logic [ERG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ERG_DATA_W-1:0] reg_rdata,
  // conversion engine events
  input wire logic result_new,
  input wire logic result_taken,
  output logic result_ready,
  // excitation source one routing
  output logic excitation_source_one_on,
  output logic [ERG_NUM_TARGETS-1:0] source_one_route,
  output logic source_one_reserved,
  // excitation source two routing
  output logic excitation_source_two_on,
  output logic [ERG_NUM_TARGETS-1:0] source_two_route,
  output logic source_two_reserved,
  // result output mode
  output logic auto_read_mode,
  // general-purpose pins
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe
);

  // ==========================================================
  // declarations
  logic [2:0] one_route_q;
  logic [2:0] one_route_d;
  logic [2:0] two_route_q;
  logic [2:0] two_route_d;
  logic auto_q;
  logic auto_d;
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] dir_d;
  logic pin2_sel_q;
  logic pin2_sel_d;
  logic [NUM_PINS-1:0] level_q;
  logic ready_q;
  logic ready_d;
  logic [ERG_DATA_W-1:0] rdata_q;
  logic [ERG_DATA_W-1:0] rdata_d;
  logic [ERG_NUM_TARGETS-1:0] one_sel_q;
  logic [ERG_NUM_TARGETS-1:0] one_sel_d;
  logic [ERG_NUM_TARGETS-1:0] two_sel_q;
  logic [ERG_NUM_TARGETS-1:0] two_sel_d;
  logic one_on_q;
  logic two_on_q;
  logic one_rsvd_q;
  logic two_rsvd_q;
  logic [NUM_PINS-1:0] pin_out_q;
  logic [NUM_PINS-1:0] pin_out_d;
  logic [NUM_PINS-1:0] pin_oe_q;

  wire hit_route = (reg_addr == ERG_ADDR_ROUTE);
  wire hit_pins = (reg_addr == ERG_ADDR_PINS);
  wire wr_route = reg_wr && hit_route;
  wire wr_pins = reg_wr && hit_pins;
  wire [ERG_DATA_W-1:0] route_view;
  wire [ERG_DATA_W-1:0] pins_view;

  // ==========================================================
  // routing and output mode register
  assign one_route_d = wr_route ? reg_wdata[ERG_ONE_ROUTE_HI:ERG_ONE_ROUTE_LO]
                                : one_route_q;
  assign two_route_d = wr_route ? reg_wdata[ERG_TWO_ROUTE_HI:ERG_TWO_ROUTE_LO]
                                : two_route_q;
  assign auto_d = wr_route ? reg_wdata[ERG_AUTO_BIT] : auto_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      one_route_q <= ERG_RESET_ROUTE[ERG_ONE_ROUTE_HI:ERG_ONE_ROUTE_LO];
      two_route_q <= ERG_RESET_ROUTE[ERG_TWO_ROUTE_HI:ERG_TWO_ROUTE_LO];
      auto_q <= ERG_RESET_ROUTE[ERG_AUTO_BIT];
    end else begin
      one_route_q <= one_route_d;
      two_route_q <= two_route_d;
      auto_q <= auto_d;
    end
  end

  // ==========================================================
  // pin control register
  assign dir_d = wr_pins ? reg_wdata[ERG_DIR_LO +: NUM_PINS] : dir_q;
  assign pin2_sel_d = wr_pins ? reg_wdata[ERG_PIN2_SEL_BIT] : pin2_sel_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_q <= ERG_RESET_PINS[ERG_DIR_LO +: NUM_PINS];
      pin2_sel_q <= ERG_RESET_PINS[ERG_PIN2_SEL_BIT];
    end else begin
      dir_q <= dir_d;
      pin2_sel_q <= pin2_sel_d;
    end
  end

  // one level bit and synchroniser per pin
  // new direction so a write that makes a pin an output also sets its level
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      erg_pin_cell u_cell (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(pin_in[gi]),
        .dir(dir_d[gi]),
        .wr_en(wr_pins),
        .wr_level(reg_wdata[ERG_LEVEL_LO + gi]),
        .level_q(level_q[gi])
      );
    end
  endgenerate

  // ==========================================================
  // result ready flag
  // a new result in the same cycle as a read keeps the flag set
  assign ready_d = result_new ? 1'b1 : (result_taken ? 1'b0 : ready_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  // ==========================================================
  // route decode
  function automatic logic [ERG_NUM_TARGETS-1:0] route_sel(input logic [2:0] code);
    logic [ERG_NUM_TARGETS-1:0] sel;
    sel = ERG_SEL_NONE;
    case (erg_route_t'(code))
      ERG_ROUTE_OFF: begin
        sel = ERG_SEL_NONE;
      end
      ERG_ROUTE_ANALOG_INPUT_ZERO: begin
        sel = ERG_SEL_ANALOG_INPUT_ZERO;
      end
      ERG_ROUTE_ANALOG_INPUT_ONE: begin
        sel = ERG_SEL_ANALOG_INPUT_ONE;
      end
      ERG_ROUTE_ANALOG_INPUT_TWO: begin
        sel = ERG_SEL_ANALOG_INPUT_TWO;
      end
      ERG_ROUTE_ANALOG_INPUT_THREE: begin
        sel = ERG_SEL_ANALOG_INPUT_THREE;
      end
      ERG_ROUTE_REFERENCE_POSITIVE_PIN: begin
        sel = ERG_SEL_REFERENCE_POSITIVE_PIN;
      end
      ERG_ROUTE_REFERENCE_NEGATIVE_PIN: begin
        sel = ERG_SEL_REFERENCE_NEGATIVE_PIN;
      end
      default: begin
        // reserved code leaves the source disconnected
        sel = ERG_SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  assign one_sel_d = route_sel(one_route_q);
  assign two_sel_d = route_sel(two_route_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      one_sel_q <= ERG_SEL_NONE;
      two_sel_q <= ERG_SEL_NONE;
      one_on_q <= 1'b0;
      two_on_q <= 1'b0;
      one_rsvd_q <= 1'b0;
      two_rsvd_q <= 1'b0;
    end else begin
      one_sel_q <= one_sel_d;
      two_sel_q <= two_sel_d;
      one_on_q <= |one_sel_d;
      two_on_q <= |two_sel_d;
      one_rsvd_q <= (one_route_q == ERG_ROUTE_RSVD);
      two_rsvd_q <= (two_route_q == ERG_ROUTE_RSVD);
    end
  end

  // ==========================================================
  // pin drivers
  always_comb begin
    pin_out_d = level_q;
    if (pin2_sel_q == ERG_PIN2_FROM_READY) begin
      pin_out_d[ERG_READY_PIN] = ready_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= dir_q;
    end
  end

  // ==========================================================
  // read back
  // reserved positions are forced to zero whatever was written
  assign route_view = {one_route_q, two_route_q, 1'b0, auto_q};
  assign pins_view = {1'b0, dir_q, pin2_sel_q, level_q};

  assign rdata_d = !reg_rd ? ERG_READ_ZERO :
                   hit_route ? route_view :
                   hit_pins ? pins_view :
                   ERG_READ_ZERO;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= ERG_READ_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = rdata_q;
  assign result_ready = ready_q;
  assign excitation_source_one_on = one_on_q;
  assign source_one_route = one_sel_q;
  assign source_one_reserved = one_rsvd_q;
  assign excitation_source_two_on = two_on_q;
  assign source_two_route = two_sel_q;
  assign source_two_reserved = two_rsvd_q;
  assign auto_read_mode = auto_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

endmodule

// [test/erg_regs_properties.sv]
// Purpose: port checker of the routing and pin registers
// Assumes: ports of erg_config_regs, single clock, sync reset
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module erg_regs_props
  import erg_pkg::*;
#(parameter int NUM_PINS = ERG_NUM_PINS)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ERG_ADDR_W-1:0] reg_addr,
  input wire logic [ERG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ERG_DATA_W-1:0] reg_rdata,
  input wire logic result_new,
  input wire logic result_taken,
  input wire logic result_ready,
  input wire logic excitation_source_two_on,
  input wire logic [ERG_NUM_TARGETS-1:0] source_one_route,
  input wire logic source_one_reserved,
  input wire logic [ERG_NUM_TARGETS-1:0] source_two_route,
  input wire logic auto_read_mode,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe
);
  // ==========================================================
  // write decodes and assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire wr3 = reg_wr && reg_addr == 8'h03;
  wire wr4 = reg_wr && reg_addr == 8'h04;
  a_route_rsvd_zero: assert property (reg_rd && reg_addr == 8'h03 |=> !reg_rdata[1])
    else $error("route reserved bit read as one");
  a_pins_rsvd_zero: assert property (reg_rd && reg_addr == 8'h04 |=> !reg_rdata[7])
    else $error("pin reserved bit read as one");
  a_auto_mode: assert property (wr3 |=> auto_read_mode == $past(reg_wdata[0]))
    else $error("output mode not taken from write");
  a_one_reference_positive_pin: assert property (wr3 && reg_wdata[7:5] == 3'h5 |-> ##2 source_one_route == 6'h10)
    else $error("source one not on positive reference");
  a_one_rsvd: assert property (wr3 && reg_wdata[7:5] == 3'h7 |-> ##2
    source_one_reserved && source_one_route == 6'h00)
    else $error("reserved code not disconnected");
  a_two_reference_negative_pin: assert property (wr3 && reg_wdata[4:2] == 3'h6 |-> ##2
    excitation_source_two_on && source_two_route == 6'h20)
    else $error("source two not on negative reference");
  a_dir_oe: assert property (wr4 |-> ##2 pin_oe == $past(reg_wdata[6:4], 2))
    else $error("pin enables differ from direction bits");
  a_out_level: assert property (wr4 && reg_wdata[4] |-> ##2 pin_out[0] == $past(reg_wdata[0], 2))
    else $error("pin 0 drive differs from level");
  a_ready_set: assert property (result_new |=> result_ready)
    else $error("ready not set by new result");
  a_ready_clr: assert property (result_taken && !result_new |=> !result_ready)
    else $error("ready not cleared by read");
  c_rsvd: cover property (wr3 ##2 source_one_reserved);
  c_ready: cover property (result_new ##1 result_ready);
  c_out: cover property (wr4 && reg_wdata[4]);
endmodule

bind erg_config_regs erg_regs_props #(.NUM_PINS(NUM_PINS)) u_props (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_new(result_new),
  .result_taken(result_taken), .result_ready(result_ready),
  .excitation_source_two_on(excitation_source_two_on), .source_one_route(source_one_route),
  .source_one_reserved(source_one_reserved), .source_two_route(source_two_route),
  .auto_read_mode(auto_read_mode), .pin_out(pin_out), .pin_oe(pin_oe));

// [test/erg_pin_partner.sv]
// Purpose: outside world of the three general-purpose pins
// Assumes: the outside drives a pin only while the block does not
// Notes: resolved level feeds pin_in
`timescale 1ns/1ns
module erg_pin_partner (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] ext_lvl,
  output logic [2:0] pin_wire
);
  // ==========================================================
  // per-pin resolution of block drive and outside drive
  assign pin_wire = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// [test/tb.sv]
// Purpose: self-checking bench of the routing and pin registers
// Assumes: 100 MHz ref_clk, reset held 4 cycles
// Notes: pins resolved by erg_pin_partner
`timescale 1ns/1ns
module tb
  import erg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic result_new = 1'b0;
  logic result_taken = 1'b0;
  logic [2:0] ext_lvl = 3'h0;
  logic [7:0] reg_rdata;
  logic result_ready, one_on, one_rsvd, two_on, two_rsvd, auto_mode;
  logic [5:0] one_route, two_route;
  logic [2:0] pin_wire, pin_out, pin_oe;
  int n_mismatch = 0;
  int n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  erg_config_regs #(.NUM_PINS(3)) uut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_new(result_new),
    .result_taken(result_taken), .result_ready(result_ready),
    .excitation_source_one_on(one_on), .source_one_route(one_route),
    .source_one_reserved(one_rsvd), .excitation_source_two_on(two_on),
    .source_two_route(two_route), .source_two_reserved(two_rsvd),
    .auto_read_mode(auto_mode), .pin_in(pin_wire), .pin_out(pin_out), .pin_oe(pin_oe));
  erg_pin_partner peer (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_wire(pin_wire));

  // ==========================================================
  // access tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic ev(input logic s);
    @(posedge ref_clk);
    result_new <= s;
    result_taken <= !s;
    @(posedge ref_clk);
    result_new <= 1'b0;
    result_taken <= 1'b0;
    @(posedge ref_clk);
    #1 chk("result_ready", {7'h00, s}, {7'h00, result_ready});
  endtask
  function automatic logic [5:0] hot(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    logic [2:0] c;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ERG_ADDR_ROUTE, ERG_RESET_ROUTE);
    rd(ERG_ADDR_PINS, ERG_RESET_PINS);
    rd(8'h05, ERG_READ_ZERO);
    chk("pin_oe", 8'h00, {5'h00, pin_oe});
    chk("pin_out", 8'h00, {5'h00, pin_out});
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(ERG_ADDR_ROUTE, {c, ~c, 1'b0, c[0]});
      rd(ERG_ADDR_ROUTE, {c, ~c, 1'b0, c[0]});
      chk("source_one_route", {2'b00, hot(c)}, {2'b00, one_route});
      chk("source_two_route", {2'b00, hot(~c)}, {2'b00, two_route});
      chk("source_one_on", {7'h00, hot(c) != 6'h00}, {7'h00, one_on});
      chk("source_one_reserved", {7'h00, c == 3'h7}, {7'h00, one_rsvd});
      chk("source_two_on", {7'h00, hot(~c) != 6'h00}, {7'h00, two_on});
      chk("source_two_reserved", {7'h00, c == 3'h0}, {7'h00, two_rsvd});
      chk("auto_read_mode", {7'h00, c[0]}, {7'h00, auto_mode});
    end
    wr(ERG_ADDR_PINS, 8'h73);
    rd(ERG_ADDR_PINS, 8'h73);
    chk("pin_oe", 8'h07, {5'h00, pin_oe});
    chk("pin_wire", 8'h03, {5'h00, pin_wire});
    wr(ERG_ADDR_PINS, 8'h4C);
    // pins 1 and 0 turn to inputs: let the synchronisers settle
    repeat (4) @(posedge ref_clk);
    rd(ERG_ADDR_PINS, 8'h4C);
    chk("pin_out", 8'h00, {7'h00, pin_out[2]});
    ev(1'b1);
    chk("pin_out", 8'h01, {7'h00, pin_out[2]});
    wr(ERG_ADDR_PINS, 8'h40);
    rd(ERG_ADDR_PINS, 8'h40);
    chk("pin_out", 8'h00, {7'h00, pin_out[2]});
    ev(1'b0);
    ext_lvl <= 3'h5;
    wr(ERG_ADDR_PINS, 8'h02);
    repeat (4) @(posedge ref_clk);
    rd(ERG_ADDR_PINS, 8'h05);
    ext_lvl <= 3'h2;
    repeat (4) @(posedge ref_clk);
    rd(ERG_ADDR_PINS, 8'h02);
    chk("pin_oe", 8'h00, {5'h00, pin_oe});
    test_done();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
endmodule
